// file: hdl/ctsp_pkg.sv
`default_nettype none
package ctsp_pkg;

   // ----------------------------------------------------------------
   // mode and clock-select encodings
   // ----------------------------------------------------------------
   localparam logic [1:0] MODE_STOP = 2'h0;
   localparam logic [1:0] MODE_TX   = 2'h1;
   localparam logic [1:0] MODE_RX   = 2'h2;
   localparam logic [1:0] MODE_TXRX = 2'h3;

   localparam logic [2:0] CKS_SLOW  = 3'h6;
   localparam logic [2:0] CKS_EXT   = 3'h7;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] TXBUF_RESET  = 8'hff;
   localparam logic       GATE_RESET   = 1'b0;
   localparam logic [7:0] CTRL_RESET   = 8'h00;
   localparam logic [7:0] STATUS_RESET = 8'h00;

   // ----------------------------------------------------------------
   // serial clock half periods, in gear cycles minus one
   // ----------------------------------------------------------------
   // codes 000..110 divide by 512,64,32,16,8,4,2; entry 7 is unused
   localparam logic [7:0] HALF_M1 [0:7] = '{8'h00ff, 8'h001f, 8'h000f, 8'h0007,
                                           8'h0003, 8'h0001, 8'h0000, 8'h0000};
   // slow mode: low-frequency clock divided by 8, half period 4 ticks
   localparam logic [7:0] SLOW_HALF_M1 = 8'h0003;
   localparam logic [2:0] LAST_BIT     = 3'h7;

   // ----------------------------------------------------------------
   // register layouts
   // ----------------------------------------------------------------
   typedef struct packed {
      logic       edgeSel;
      logic [2:0] clkSel;
      logic       bitOrder;
      logic       start;
      logic [1:0] mode;
   } ctsp_ctrl_t;

   typedef struct packed {
      logic       transferActive;
      logic       shiftActive;
      logic       rxOverrun;
      logic       rxDone;
      logic       txUnderrun;
      logic       bufferFull;
      logic [1:0] unused;
   } ctsp_status_t;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_SHIFT,
      ST_WAIT
   } ctsp_state_t;

endpackage
`default_nettype wire

// file: hdl/ctsp_transmit_port.sv
`default_nettype none
module ctsp_transmit_port #(
   parameter int unsigned FIFO_DEPTH = 2,
   parameter int unsigned DATA_W     = 8
) (
   input  wire logic               clk,
   input  wire logic               reset,
   input  wire logic               gateWrite,
   input  wire logic               gateData,
   output var  logic               portClockEnable,
   input  wire logic               ctrlWrite,
   input  wire ctsp_pkg::ctsp_ctrl_t ctrlData,
   output var  ctsp_pkg::ctsp_ctrl_t ctrlReg,
   input  wire logic               dataValid,
   input  wire logic [DATA_W-1:0]  dataIn,
   output var  logic               dataReady,
   input  wire logic               slowMode,
   input  wire logic               lowFreqTick,
   input  wire logic               serialClockIn,
   output var  logic               serialClockOut,
   output var  logic               serialClockOe,
   output var  logic               serialOutputPin,
   output var  ctsp_pkg::ctsp_status_t statusReg,
   output var  logic               serialPortIrq
);

   localparam int unsigned PTR_W = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
   localparam int unsigned CNT_W = $clog2(FIFO_DEPTH + 1);

   ctsp_pkg::ctsp_state_t state_r;
   logic [DATA_W-1:0]     txBuf_r;
   logic [DATA_W-1:0]     shift_r;
   logic [2:0]            bitCnt_r;
   logic                  lastBit_r;
   logic                  stopPending_r;
   logic                  irqHeld_r;
   logic [7:0]            divCnt_r;
   logic                  sync1_r;
   logic                  sync2_r;
   logic                  sync3_r;
   logic                  extLevel_r;
   logic                  extPrev_r;
   logic [DATA_W-1:0]     fifoMem_r [0:FIFO_DEPTH-1];
   logic [PTR_W-1:0]      wrPtr_r;
   logic [PTR_W-1:0]      rdPtr_r;
   logic [CNT_W-1:0]      fifoCnt_r;
   logic [CNT_W-1:0]      fifoCnt_nxt;

   // ----------------------------------------------------------------
   // write-side buffer
   // ----------------------------------------------------------------
   // drains only while the port is clocked, so a gated port back-pressures the writer
   wire en        = portClockEnable;
   wire push      = dataValid & dataReady;
   wire pop       = (fifoCnt_r != '0) & en;
   wire [DATA_W-1:0] popData = fifoMem_r[rdPtr_r];
   assign fifoCnt_nxt = fifoCnt_r + CNT_W'(push) - CNT_W'(pop);

   always_ff @(posedge clk) begin
      if (reset) begin
         wrPtr_r   <= '0;
         rdPtr_r   <= '0;
         fifoCnt_r <= '0;
         dataReady <= 1'b0;
      end else begin
         fifoCnt_r <= fifoCnt_nxt;
         dataReady <= (fifoCnt_nxt != CNT_W'(FIFO_DEPTH));
         if (push) begin
            wrPtr_r <= (wrPtr_r == PTR_W'(FIFO_DEPTH - 1)) ? '0 : wrPtr_r + 1'b1;
         end
         if (pop) begin
            rdPtr_r <= (rdPtr_r == PTR_W'(FIFO_DEPTH - 1)) ? '0 : rdPtr_r + 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (push) begin
         fifoMem_r[wrPtr_r] <= dataIn;
      end
   end

   // ----------------------------------------------------------------
   // external clock synchroniser
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         sync1_r    <= 1'b1;
         sync2_r    <= 1'b1;
         sync3_r    <= 1'b1;
         extLevel_r <= 1'b1;
         extPrev_r  <= 1'b1;
      end else begin
         sync1_r   <= serialClockIn;
         sync2_r   <= sync1_r;
         sync3_r   <= sync2_r;
         extPrev_r <= extLevel_r;
         if (sync2_r == sync3_r) begin
            extLevel_r <= sync3_r;
         end
      end
   end

   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   wire active      = statusReg.transferActive;
   wire internalClk = ctrlReg.clkSel != ctsp_pkg::CKS_EXT;
   wire idleLevel   = ~ctrlReg.edgeSel;
   wire cksValid    = ~slowMode | (ctrlReg.clkSel == ctsp_pkg::CKS_SLOW);
   wire [7:0] limit = slowMode ? ctsp_pkg::SLOW_HALF_M1 : ctsp_pkg::HALF_M1[ctrlReg.clkSel];
   wire running     = en & (state_r == ctsp_pkg::ST_SHIFT) & internalClk & cksValid;
   wire divStep     = slowMode ? lowFreqTick : 1'b1;
   wire tickInt     = running & divStep & (divCnt_r == limit);
   wire intTx       = tickInt & (serialClockOut == idleLevel);
   wire intSample   = tickInt & (serialClockOut != idleLevel);
   wire extRise     = extLevel_r & ~extPrev_r;
   wire extFall     = ~extLevel_r & extPrev_r;
   wire extGo       = en & ~internalClk & (state_r == ctsp_pkg::ST_SHIFT);
   wire extTx       = extGo & (ctrlReg.edgeSel ? extRise : extFall);
   wire extSample   = extGo & (ctrlReg.edgeSel ? extFall : extRise);
   wire txEdge      = intTx | extTx;
   wire sampleEdge  = intSample | extSample;

   wire cfgAccept   = ctrlWrite & en & ~active;
   wire forceStop   = ctrlWrite & en & (ctrlData.mode == ctsp_pkg::MODE_STOP);
   wire startReq    = cfgAccept & ctrlData.start & (ctrlData.mode == ctsp_pkg::MODE_TX);
   wire stopReq     = ctrlWrite & en & active & ~ctrlData.start & ~forceStop;
   wire stopNow     = stopReq & (state_r == ctsp_pkg::ST_WAIT);
   wire byteDone    = sampleEdge & lastBit_r & ~forceStop;
   wire reloadBuf   = byteDone & statusReg.bufferFull;
   wire finishStop  = byteDone & ~statusReg.bufferFull & stopPending_r;
   wire goWait      = byteDone & ~statusReg.bufferFull & ~stopPending_r;
   // a byte arriving with the shifter empty bypasses the buffer
   wire emptyLoad   = pop & ~forceStop & ~stopNow & ((state_r == ctsp_pkg::ST_WAIT) | goWait);
   wire fullWrite   = pop & ~forceStop & (state_r == ctsp_pkg::ST_SHIFT) & ~goWait;
   wire idleWrite   = pop & ((state_r == ctsp_pkg::ST_IDLE) | stopNow);
   wire txBit       = ctrlReg.bitOrder ? shift_r[DATA_W-1] : shift_r[0];
   wire [DATA_W-1:0] shiftNext = ctrlReg.bitOrder ? {shift_r[DATA_W-2:0], 1'b0} : {1'b0, shift_r[DATA_W-1:1]};
   wire irqEvent    = startReq | emptyLoad | reloadBuf | stopNow | finishStop;

   ctsp_pkg::ctsp_ctrl_t ctrlNext;
   always_comb begin
      ctrlNext = ctrlReg;
      if (forceStop) begin
         ctrlNext.mode  = ctsp_pkg::MODE_STOP;
         ctrlNext.start = 1'b0;
         if (!active) begin
            ctrlNext.edgeSel  = ctrlData.edgeSel;
            ctrlNext.clkSel   = ctrlData.clkSel;
            ctrlNext.bitOrder = ctrlData.bitOrder;
         end
      end else if (cfgAccept) begin
         ctrlNext       = ctrlData;
         ctrlNext.start = startReq;
      end else if (stopNow | finishStop) begin
         ctrlNext.start = 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // clock gate and control register
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         portClockEnable <= ctsp_pkg::GATE_RESET;
         ctrlReg         <= ctsp_pkg::CTRL_RESET;
         serialClockOe   <= 1'b1;
         serialPortIrq   <= 1'b0;
         irqHeld_r       <= 1'b0;
      end else begin
         if (gateWrite) begin
            portClockEnable <= gateData;
         end
         ctrlReg       <= ctrlNext;
         serialClockOe <= ctrlNext.clkSel != ctsp_pkg::CKS_EXT;
         // an event right behind another is held one cycle so the pulses stay apart
         serialPortIrq <= (irqEvent | irqHeld_r) & ~serialPortIrq;
         irqHeld_r     <= (irqEvent | irqHeld_r) & serialPortIrq;
      end
   end

   // ----------------------------------------------------------------
   // internal divider
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (reset || !running) begin
         divCnt_r <= '0;
      end else if (divStep) begin
         divCnt_r <= tickInt ? 8'h0000 : divCnt_r + 8'h0001;
      end
   end

   // ----------------------------------------------------------------
   // transmit sequencer
   // ----------------------------------------------------------------
   // the sequencer holds while the gate is low but the divider clears; ungating mid-byte resumes the byte at the bit where it stopped
   always_ff @(posedge clk) begin
      if (reset) begin
         state_r         <= ctsp_pkg::ST_IDLE;
         statusReg       <= ctsp_pkg::STATUS_RESET;
         txBuf_r         <= ctsp_pkg::TXBUF_RESET;
         shift_r         <= ctsp_pkg::TXBUF_RESET;
         bitCnt_r        <= '0;
         lastBit_r       <= 1'b0;
         stopPending_r   <= 1'b0;
         serialOutputPin <= 1'b1;
         serialClockOut  <= 1'b1;
      end else if (en) begin
         if (forceStop) begin
            state_r         <= ctsp_pkg::ST_IDLE;
            statusReg       <= ctsp_pkg::STATUS_RESET;
            lastBit_r       <= 1'b0;
            bitCnt_r        <= '0;
            stopPending_r   <= 1'b0;
            serialOutputPin <= 1'b1;
            serialClockOut  <= ~ctrlNext.edgeSel;
         end else begin
            if (cfgAccept) begin
               serialClockOut <= ~ctrlData.edgeSel;
            end
            if (startReq) begin
               state_r                  <= ctsp_pkg::ST_SHIFT;
               shift_r                  <= txBuf_r;
               statusReg.transferActive <= 1'b1;
               statusReg.shiftActive    <= 1'b1;
               bitCnt_r                 <= '0;
            end
            if (stopReq & ~stopNow) begin
               stopPending_r <= 1'b1;
            end
            if (intTx) begin
               serialClockOut <= ~idleLevel;
            end
            if (intSample) begin
               serialClockOut <= idleLevel;
            end
            if (txEdge) begin
               serialOutputPin <= txBit;
               shift_r         <= shiftNext;
               bitCnt_r        <= bitCnt_r + 3'h1;
               if (bitCnt_r == ctsp_pkg::LAST_BIT) begin
                  lastBit_r             <= 1'b1;
                  statusReg.shiftActive <= 1'b0;
               end
            end
            if (byteDone) begin
               lastBit_r <= 1'b0;
               bitCnt_r  <= '0;
            end
            if (reloadBuf) begin
               shift_r                <= txBuf_r;
               statusReg.bufferFull   <= 1'b0;
               statusReg.shiftActive  <= 1'b1;
            end
            if (goWait) begin
               state_r <= ctsp_pkg::ST_WAIT;
               if (internalClk) begin
                  serialOutputPin <= 1'b1;
               end
            end
            if (finishStop | stopNow) begin
               state_r         <= ctsp_pkg::ST_IDLE;
               statusReg       <= ctsp_pkg::STATUS_RESET;
               stopPending_r   <= 1'b0;
               if (internalClk) begin
                  serialOutputPin <= 1'b1;
               end
            end
            if (idleWrite | fullWrite) begin
               txBuf_r <= popData;
            end
            if (fullWrite) begin
               statusReg.bufferFull <= 1'b1;
            end
            if (emptyLoad) begin
               state_r               <= ctsp_pkg::ST_SHIFT;
               shift_r               <= popData;
               statusReg.shiftActive <= 1'b1;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   a_gate_reset: assert property (@(posedge clk) reset |=> !portClockEnable)
      else $error("clock enable not low after reset");

   a_gate_freeze: assert property (@(posedge clk) disable iff (reset)
      !portClockEnable |=> $stable(statusReg) && $stable(serialOutputPin))
      else $error("port state moved while gated");

   a_start_flags: assert property (@(posedge clk) disable iff (reset)
      startReq |=> statusReg.transferActive && statusReg.shiftActive && (serialPortIrq || irqHeld_r))
      else $error("start did not set flags and interrupt");

   a_irq_pulse: assert property (@(posedge clk) disable iff (reset)
      serialPortIrq |=> !serialPortIrq)
      else $error("interrupt not a single pulse");

   a_cfg_locked: assert property (@(posedge clk) disable iff (reset)
      ctrlWrite && statusReg.transferActive && ctrlData.mode != ctsp_pkg::MODE_STOP
      |=> ctrlReg.clkSel == $past(ctrlReg.clkSel) && ctrlReg.edgeSel == $past(ctrlReg.edgeSel)
          && ctrlReg.bitOrder == $past(ctrlReg.bitOrder) && ctrlReg.mode == $past(ctrlReg.mode))
      else $error("config changed during transfer");

   a_force_stop: assert property (@(posedge clk) disable iff (reset)
      forceStop |=> statusReg == ctsp_pkg::STATUS_RESET && serialOutputPin && !ctrlReg.start)
      else $error("forced stop left status set");

   a_bit_order: assert property (@(posedge clk) disable iff (reset)
      txEdge && !forceStop |=> serialOutputPin == (ctrlReg.bitOrder ? $past(shift_r[DATA_W-1]) : $past(shift_r[0])))
      else $error("wrong bit driven");

   a_sef_clear: assert property (@(posedge clk) disable iff (reset)
      txEdge && bitCnt_r == ctsp_pkg::LAST_BIT && !forceStop && !emptyLoad |=> !statusReg.shiftActive)
      else $error("shift flag not cleared at eighth bit");

   a_buffer_full: assert property (@(posedge clk) disable iff (reset)
      fullWrite |=> statusReg.bufferFull && txBuf_r == $past(popData))
      else $error("buffer write while shifting not flagged");

   a_empty_load: assert property (@(posedge clk) disable iff (reset)
      emptyLoad |=> !statusReg.bufferFull && shift_r == $past(popData) && (serialPortIrq || irqHeld_r))
      else $error("direct load failed");

   a_wait_idle: assert property (@(posedge clk) disable iff (reset)
      state_r == ctsp_pkg::ST_WAIT && internalClk
      |-> serialOutputPin && serialClockOut == idleLevel && !statusReg.shiftActive)
      else $error("automatic wait not idle");

   a_edge_sel: assert property (@(posedge clk) disable iff (reset)
      intTx && !forceStop |=> serialClockOut == ctrlReg.edgeSel)
      else $error("transmit edge has wrong direction");

   a_ext_release: assert property (@(posedge clk) disable iff (reset)
      ctrlReg.clkSel == ctsp_pkg::CKS_EXT |-> !serialClockOe)
      else $error("driving clock pin in external mode");

endmodule
`default_nettype wire

// file: dv/ctsp_serial_peer.sv
`default_nettype none
module ctsp_serial_peer #(
   parameter int EXT_HALF = 8
) (
   input  wire logic        clk,
   input  wire logic        clockOe,
   input  wire logic        clockOut,
   input  wire logic        dataPin,
   input  wire logic        edgeSel,
   input  wire logic        extStart,
   input  wire logic        clear,
   output var  logic        clockWire,
   output var  logic [7:0]  rxByte  = 8'h00,
   output var  logic [15:0] rxCount = 16'h0000,
   output var  logic [15:0] period  = 16'h0000
);
   timeunit 1ns;
   timeprecision 100ps;
   // --------
   // clock pin and byte capture
   // --------
   logic        peerClk = 1'b1;
   logic        wasIdle = 1'b1;
   // the edge is seen a cycle late, so take the data as it stood before it
   logic        dataPrev = 1'b1;
   logic [2:0]  bitCnt  = 3'h0;
   logic [15:0] gap     = 16'h0000;
   int          toggles = 0;
   int          halfCnt = 0;
   wire         idleLvl = ~edgeSel;
   wire         atIdle  = (clockWire == idleLvl);
   // the peer owns the pin only while the device has released it
   assign clockWire = clockOe ? clockOut : peerClk;
   always @(posedge clk) begin
      // one frame of eight pulses per request, idle in between
      if (extStart) toggles <= 16;
      if (toggles == 0) peerClk <= idleLvl;
      else if (halfCnt == EXT_HALF - 1) begin
         halfCnt <= 0;
         peerClk <= ~peerClk;
         toggles <= toggles - 1;
      end
      else halfCnt <= halfCnt + 1;
      wasIdle <= atIdle;
      dataPrev <= dataPin;
      gap <= gap + 16'h0001;
      // bits land in arrival order, first bit ends up in bit 0
      if (clear) bitCnt <= 3'h0;
      else if (atIdle && !wasIdle) begin
         rxByte <= {dataPrev, rxByte[7:1]};
         bitCnt <= bitCnt + 3'h1;
         gap <= 16'h0001;
         if (bitCnt != 3'h0) period <= gap;
         if (bitCnt == 3'h7) rxCount <= rxCount + 16'h0001;
      end
   end
endmodule
`default_nettype wire

// file: dv/ctsp_transmit_port_tb_top.sv
`default_nettype none
module ctsp_transmit_port_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   // --------
   // signals
   // --------
   logic                   clk = 1'b0, reset = 1'b1, gateWrite = 1'b0, gateData = 1'b0;
   logic                   ctrlWrite = 1'b0, dataValid = 1'b0, slowMode = 1'b0, lowFreqTick = 1'b0;
   logic                   extStart = 1'b0, clear = 1'b0, lastIrq = 1'b0;
   logic                   portClockEnable, dataReady, clockWire, serialClockOut, serialClockOe;
   logic                   serialOutputPin, serialPortIrq;
   logic [7:0]             dataIn = 8'h00, rxByte;
   logic [15:0]            rxCount, period, n;
   ctsp_pkg::ctsp_ctrl_t   ctrlData = '0, ctrlReg;
   ctsp_pkg::ctsp_status_t statusReg;
   int                     failures = 0, checks = 0, irqCount = 0, lfCnt = 0, irq0 = 0;

   initial forever #12.5 clk = ~clk;

   ctsp_transmit_port u_dut (.clk(clk), .reset(reset), .gateWrite(gateWrite), .gateData(gateData),
      .portClockEnable(portClockEnable), .ctrlWrite(ctrlWrite), .ctrlData(ctrlData), .ctrlReg(ctrlReg),
      .dataValid(dataValid), .dataIn(dataIn), .dataReady(dataReady), .slowMode(slowMode),
      .lowFreqTick(lowFreqTick), .serialClockIn(clockWire), .serialClockOut(serialClockOut),
      .serialClockOe(serialClockOe), .serialOutputPin(serialOutputPin), .statusReg(statusReg),
      .serialPortIrq(serialPortIrq));

   ctsp_serial_peer u_peer (.clk(clk), .clockOe(serialClockOe), .clockOut(serialClockOut),
      .dataPin(serialOutputPin), .edgeSel(ctrlReg.edgeSel), .extStart(extStart), .clear(clear),
      .clockWire(clockWire), .rxByte(rxByte), .rxCount(rxCount), .period(period));

   // low-frequency tick every fifth cycle keeps the slow run short
   always begin
      @(posedge clk);
      #2;
      lfCnt = (lfCnt == 4) ? 0 : lfCnt + 1;
      lowFreqTick = (lfCnt == 0);
   end

   always @(posedge clk) begin
      if (serialPortIrq === 1'b1) irqCount++;
      if (serialPortIrq === 1'b1) chk("irq width", 16'h0000, {15'h0000, lastIrq});
      lastIrq = serialPortIrq;
   end
   // --------
   // tasks
   // --------
   task automatic tick(int k = 1);
      repeat (k) @(posedge clk);
      #2;
   endtask
   task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic close_out();
      if (failures == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // trailing idle cycle keeps two strobes from landing in one time step
   task automatic wrCtrl(logic e, logic [2:0] cks, logic ord, logic st, logic [1:0] m);
      ctrlData = '{edgeSel: e, clkSel: cks, bitOrder: ord, start: st, mode: m};
      ctrlWrite = 1'b1;
      tick();
      ctrlWrite = 1'b0;
      tick();
   endtask
   task automatic push(logic [7:0] b);
      dataIn = b;
      dataValid = 1'b1;
      for (int i = 0; i < 50 && dataReady !== 1'b1; i++) tick();
      chk("ready", 16'h0001, {15'h0000, dataReady});
      tick();
      dataValid = 1'b0;
      tick(2);
   endtask
   task automatic waitRx(logic [15:0] cnt);
      for (int i = 0; i < 6000 && rxCount !== cnt; i++) tick();
      if (rxCount !== cnt) begin
         failures++;
         close_out();
      end
   endtask
   // a config change can fake a clock edge at the peer, so realign it afterwards
   task automatic cfg(logic e, logic [2:0] cks, logic ord);
      wrCtrl(e, cks, ord, 1'b0, ctsp_pkg::MODE_TX);
      clear = 1'b1;
      tick(3);
      clear = 1'b0;
   endtask
   task automatic sendOne(logic e, logic [2:0] cks, logic ord, logic [7:0] b, logic [15:0] per);
      logic [7:0] exp;
      exp = b;
      if (ord) exp = {<<{b}};
      n = rxCount + 16'h0001;
      cfg(e, cks, ord);
      push(b);
      irq0 = irqCount;
      wrCtrl(e, cks, ord, 1'b1, ctsp_pkg::MODE_TX);
      chk("start flags", 8'hc0, statusReg);
      chk("clock drive", cks != ctsp_pkg::CKS_EXT, serialClockOe);
      if (cks == ctsp_pkg::CKS_EXT) begin
         extStart = 1'b1;
         tick();
         extStart = 1'b0;
      end
      waitRx(n);
      chk("byte", exp, rxByte);
      chk("period", per, period);
      tick(4);
      chk("wait flags", 8'h80, statusReg);
      if (cks != ctsp_pkg::CKS_EXT) begin
         chk("wait pins", {14'h0000, 1'b1, ~e}, {14'h0000, serialOutputPin, serialClockOut});
      end
      wrCtrl(e, cks, ord, 1'b0, ctsp_pkg::MODE_TX);
      chk("stop flags", 8'h00, statusReg);
      chk("irq count", irq0 + 2, irqCount);
   endtask
   // --------
   // scenarios
   // --------
   initial begin
      tick(5);
      reset = 1'b0;
      tick(2);
      chk("reset state", 16'h0001, {portClockEnable, statusReg, ctrlReg[6:0]} ^ serialOutputPin);
      wrCtrl(1'b0, 3'h4, 1'b0, 1'b1, ctsp_pkg::MODE_TX);
      chk("gated ctrl", 8'h00, ctrlReg);
      gateData = 1'b1;
      gateWrite = 1'b1;
      tick();
      // enable stays high for the rest of the run
      gateWrite = 1'b0;
      tick();
      chk("enable", 16'h0001, {15'h0000, portClockEnable});
      for (int c = 0; c < 7; c++) sendOne(c[0], c[2:0], c[1], 8'h1d + 8'h26 * c[7:0],
                                          (c == 0) ? 16'h0200 : (16'h0080 >> c));
      slowMode = 1'b1;
      sendOne(1'b0, ctsp_pkg::CKS_SLOW, 1'b1, 8'hb1, 16'h0028);
      slowMode = 1'b0;
      sendOne(1'b0, ctsp_pkg::CKS_EXT, 1'b1, 8'h6e, 16'h0010);
      cfg(1'b0, 3'h4, 1'b0);
      push(8'ha1);
      n = rxCount;
      irq0 = irqCount;
      wrCtrl(1'b0, 3'h4, 1'b0, 1'b1, ctsp_pkg::MODE_TX);
      push(8'hb2);
      chk("buffer full", 8'hc4, statusReg);
      push(8'hc3);
      wrCtrl(1'b1, 3'h0, 1'b1, 1'b1, ctsp_pkg::MODE_TXRX);
      chk("locked ctrl", 8'h45, ctrlReg);
      waitRx(n + 16'h0001);
      chk("first byte", 8'ha1, rxByte);
      waitRx(n + 16'h0002);
      chk("overwritten byte", 8'hc3, rxByte);
      tick(4);
      chk("drained", 8'h80, statusReg);
      push(8'h96);
      chk("direct load", 8'hc0, statusReg);
      wrCtrl(1'b0, 3'h4, 1'b0, 1'b0, ctsp_pkg::MODE_TX);
      chk("stop pending", 8'hc0, statusReg);
      waitRx(n + 16'h0003);
      chk("last byte", 8'h96, rxByte);
      tick(4);
      chk("stopped", 8'h00, statusReg);
      chk("irq count", irq0 + 4, irqCount);
      cfg(1'b0, 3'h2, 1'b0);
      push(8'h77);
      wrCtrl(1'b0, 3'h2, 1'b0, 1'b1, ctsp_pkg::MODE_TX);
      tick(40);
      wrCtrl(1'b0, 3'h2, 1'b0, 1'b0, ctsp_pkg::MODE_STOP);
      chk("forced status", 8'h00, statusReg);
      chk("forced ctrl", 8'h20, ctrlReg);
      chk("forced pins", 2'h3, {serialOutputPin, serialClockOut});
      for (int m = 3; m > 0; m--) begin
         wrCtrl(1'b0, 3'h2, 1'b0, 1'b1, m[1:0]);
         chk("start kept", m == 1, ctrlReg.start);
         wrCtrl(1'b0, 3'h2, 1'b0, 1'b0, ctsp_pkg::MODE_STOP);
      end
      close_out();
   end
endmodule
`default_nettype wire
